// ### dv/sar_adc_window_burst_control_tb.sv
// self-checking bench for the sar converter burst and window control
// assumes swb_top with its default offset value and the mux model
`timescale 1ns/10ps
`include "swb_defs.svh"

module sar_adc_window_burst_control_tb;
	import swb_pkg::*;
	typedef struct packed {
		logic        r12, lj, outw;
		swb_acc_t    acc;
		logic [11:0] lvl;
		logic [15:0] lo, hi, res;
		logic        flg;
	} swb_row_s;
	logic        clock = 1'b0, rst = 1'b1, enable = 1'b1, burst_en = 1'b0;
	logic        res12 = 1'b0, lp_track = 1'b0, left_just = 1'b0;
	logic        win_outside = 1'b0, start = 1'b0, flag_clear = 1'b0;
	swb_acc_t    accum_sel = 3'h0;
	logic [11:0] level = 12'h000, sar_code;
	logic [15:0] lo_lim = 16'h0000, hi_lim = 16'h0000, conv_res;
	logic        comp_in, apwr, track_en, busy, rvalid, irq, pwr;
	logic [7:0]  toff_h, toff_l;
	int          n_errors = 0, cmp_count = 0, cyc, trk, n;
	// res12 lj out acc level lower upper result flag
	swb_row_s rows [14] = '{
		'{1'b0,1'b0,1'b0,3'h0,12'h050,16'h0040,16'h0080,16'h0050,1'b1},
		'{1'b0,1'b0,1'b0,3'h0,12'h040,16'h0040,16'h0080,16'h0040,1'b0},
		'{1'b0,1'b0,1'b0,3'h0,12'h080,16'h0040,16'h0080,16'h0080,1'b0},
		'{1'b0,1'b0,1'b1,3'h0,12'h03f,16'h0040,16'h0080,16'h003f,1'b1},
		'{1'b0,1'b0,1'b1,3'h0,12'h040,16'h0040,16'h0080,16'h0040,1'b0},
		'{1'b0,1'b0,1'b1,3'h0,12'h081,16'h0040,16'h0080,16'h0081,1'b1},
		'{1'b0,1'b1,1'b0,3'h0,12'h050,16'h1000,16'h2000,16'h1400,1'b1},
		'{1'b1,1'b0,1'b1,3'h0,12'habc,16'h0100,16'h0200,16'h0abc,1'b1},
		'{1'b1,1'b1,1'b0,3'h0,12'habc,16'hab00,16'hac00,16'habc0,1'b1},
		'{1'b0,1'b0,1'b0,3'h0,12'h3ff,16'h0000,16'h03ff,16'h03ff,1'b0},
		'{1'b0,1'b0,1'b0,3'h1,12'h123,16'h048b,16'h048d,16'h048c,1'b1},
		'{1'b0,1'b0,1'b1,3'h5,12'h3ff,16'h0000,16'hff00,16'hffc0,1'b1},
		'{1'b0,1'b0,1'b0,3'h6,12'h005,16'h0005,16'h0006,16'h0005,1'b0},
		'{1'b1,1'b1,1'b1,3'h1,12'hfff,16'h3ffc,16'h3ffc,16'h3ffc,1'b0}
	};

	swb_top uut (
		.clock                    (clock),
		.rst                      (rst),
		.enable                   (enable),
		.burst_en                 (burst_en),
		.res12                    (res12),
		.lp_track                 (lp_track),
		.left_just                (left_just),
		.win_outside              (win_outside),
		.accum_sel                (accum_sel),
		.start                    (start),
		.comp_in                  (comp_in),
		.window_lower_limit       (lo_lim),
		.window_upper_limit       (hi_lim),
		.flag_clear               (flag_clear),
		.analog_power             (apwr),
		.track_en                 (track_en),
		.sar_code                 (sar_code),
		.busy                     (busy),
		.conversion_result        (conv_res),
		.result_valid             (rvalid),
		.window_compare_irq_flag  (irq),
		.factory_temp_offset_high (toff_h),
		.factory_temp_offset_low  (toff_l)
	);

	swb_mux_model mux (
		.level    (level),
		.sar_code (sar_code),
		.comp_in  (comp_in)
	);

	always #5 clock = ~clock;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("errors=%0d checks=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one start pulse, then count cycles until the result pulse
	task automatic conv;
		cyc = 0;
		trk = 0;
		pwr = 1'b0;
		@(negedge clock) start = 1'b1;
		@(negedge clock) start = 1'b0;
		while (rvalid !== 1'b1 && cyc < 30000) begin
			trk += (track_en === 1'b1);
			pwr |= (apwr === 1'b1);
			@(negedge clock);
			cyc++;
		end
		if (cyc >= 30000) n_errors++;
	endtask

	// clear the sticky flag between rows so each row stands alone
	task automatic set_row(input swb_row_s r);
		@(negedge clock);
		{res12, left_just, win_outside} = {r.r12, r.lj, r.outw};
		{accum_sel, level, lo_lim, hi_lim} = {r.acc, r.lvl, r.lo, r.hi};
		flag_clear = 1'b1;
		@(negedge clock) flag_clear = 1'b0;
	endtask

	initial begin
		#1000000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (12) @(negedge clock);
		check({12'h000, busy, rvalid, irq, apwr}, 16'h0000);
		check({toff_h, toff_l}, `SWB_TOFF_RST);
		rst = 1'b0;
		@(negedge clock);
		check({15'h0000, apwr}, 16'h0001);
		foreach (rows[i]) begin
			set_row(rows[i]);
			conv();
			n = (rows[i].acc == 3'h0 || rows[i].acc > 3'h5) ? 1
				: (2 << rows[i].acc);
			check(conv_res, rows[i].res);
			check({4'h0, sar_code}, {4'h0, rows[i].lvl});
			check({15'h0000, irq}, {15'h0000, rows[i].flg});
			check({15'h0000, cyc >= (n - 1) * (rows[i].r12
				? `SWB_PER12_CYC : `SWB_PER10_CYC)}, 16'h0001);
		end
		// sticky flag survives a later miss until cleared
		set_row(rows[0]);
		conv();
		level = 12'h010;
		conv();
		check({15'h0000, irq}, 16'h0001);
		@(negedge clock) flag_clear = 1'b1;
		@(negedge clock) flag_clear = 1'b0;
		check({15'h0000, irq}, 16'h0000);
		// low-power tracking length in system clocks
		lp_track = 1'b1;
		set_row(rows[0]);
		conv();
		check(16'(trk), 16'(3 * `SWB_SAR_DIV));
		check(conv_res, 16'h0050);
		// burst: powers up, converts, powers down on its own
		lp_track = 1'b0;
		burst_en = 1'b1;
		@(negedge clock);
		@(negedge clock);
		check({15'h0000, apwr}, 16'h0000);
		conv();
		check({15'h0000, pwr}, 16'h0001);
		check({15'h0000, apwr}, 16'h0000);
		check({15'h0000, cyc > `SWB_WAKE_CYC}, 16'h0001);
		check(conv_res, 16'h0050);
		// start with the converter off is ignored
		burst_en = 1'b0;
		enable = 1'b0;
		@(negedge clock) start = 1'b1;
		@(negedge clock) start = 1'b0;
		@(negedge clock);
		check({15'h0000, busy}, 16'h0000);
		check({15'h0000, apwr}, 16'h0000);
		// reset in mid-sequence clears everything, then runs again
		enable = 1'b1;
		@(negedge clock) start = 1'b1;
		@(negedge clock) start = 1'b0;
		repeat (20) @(negedge clock);
		check({15'h0000, busy}, 16'h0001);
		rst = 1'b1;
		@(negedge clock);
		check({12'h000, busy, rvalid, irq, apwr}, 16'h0000);
		rst = 1'b0;
		@(negedge clock);
		check({15'h0000, apwr}, 16'h0001);
		conv();
		check(conv_res, 16'h0050);
		check({15'h0000, irq}, 16'h0001);
		tally_and_finish();
	end
endmodule

// ### dv/swb_mux_model.sv
// analog input mux and comparator model facing the sar converter
// assumes the bench holds one steady input level per conversion
`timescale 1ns/10ps

module swb_mux_model (
	input  wire logic [11:0] level,    // sampled input code
	input  wire logic [11:0] sar_code, // trial code from the design
	output logic             comp_in   // input at or above trial
);
	// ideal comparator: no noise, so every result is exact
	assign comp_in = (level >= sar_code);
endmodule

// ### hw/swb_top.sv
// control logic of a sar converter: burst sequencing, sample accumulation,
// resolution modes, low-power tracking and the window detector.
// assumes all inputs synchronous to clock and config held while busy.
`timescale 1ns/10ps
`include "swb_defs.svh"

module swb_top #(
	parameter logic [15:0] TEMP_OFFSET = `SWB_TOFF_RST // arbitrary value
) (
	input  wire logic             clock,                   // 100 MHz
	input  wire logic             rst,                     // async, high
	input  wire logic             enable,                  // converter on
	input  wire logic             burst_en,                // burst mode
	input  wire logic             res12,                   // 12-bit mode
	input  wire logic             lp_track,                // low-power track
	input  wire logic             left_just,               // left-justify
	input  wire logic             win_outside,             // outside window
	input  wire swb_pkg::swb_acc_t accum_sel,              // sample count
	input  wire logic             start,                   // start request
	input  wire logic             comp_in,                 // input >= trial
	input  wire logic [15:0]      window_lower_limit,      // lower limit
	input  wire logic [15:0]      window_upper_limit,      // upper limit
	input  wire logic             flag_clear,              // clear irq flag
	output logic                  analog_power,            // analog enable
	output logic                  track_en,                // sample switch
	output logic [11:0]           sar_code,                // trial code
	output logic                  busy,                    // sequence active
	output logic [15:0]           conversion_result,       // final result
	output logic                  result_valid,            // result pulse
	output logic                  window_compare_irq_flag, // window hit
	output logic [7:0]            factory_temp_offset_high, // offset msb
	output logic [7:0]            factory_temp_offset_low   // offset lsb
);
	import swb_pkg::*;

	swb_state_e  state_q, state_d;
	logic [1:0]  div_q;
	logic [7:0]  wake_q;
	logic [1:0]  trk_q;
	logic [3:0]  idx_q;
	logic [11:0] code_q;
	logic [15:0] acc_q;
	logic [6:0]  nsamp_q;
	logic [10:0] gap_q;
	logic [15:0] result_q;
	logic        valid_q;
	logic        flag_q;
	logic        power_q;

	// sample count per accumulate select; reserved codes take one
	function automatic logic [6:0] acc_count(input swb_acc_t sel);
		unique case (sel)
			3'h1: acc_count = 7'h04;
			3'h2: acc_count = 7'h08;
			3'h3: acc_count = 7'h10;
			3'h4: acc_count = 7'h20;
			3'h5: acc_count = 7'h40;
			default: acc_count = 7'h01;
		endcase
	endfunction

	// one sar step: settle the current bit, raise the next trial bit
	function automatic logic [11:0] sar_step(input logic [11:0] code,
		input logic [3:0] idx, input logic keep);
		logic [11:0] c;
		c = code;
		if (!keep) begin
			c[idx] = 1'b0;
		end
		if (idx != 4'h0) begin
			c[idx - 4'h1] = 1'b1;
		end
		sar_step = c;
	endfunction

	// mode decode
	wire        sar_tick  = div_q == 2'(`SWB_SAR_DIV - 1);
	wire [3:0]  msb_idx   = res12 ? `SWB_MSB12 : `SWB_MSB10;
	wire [10:0] period    = res12 ? 11'(`SWB_PER12_CYC)
		: 11'(`SWB_PER10_CYC);
	wire [6:0]  target    = acc_count(accum_sel);
	wire        track_end = !lp_track
		|| (sar_tick && trk_q == 2'(`SWB_TRACK_LP_SAR - 1));
	// sar clock restarts on tracking entry so low-power tracking is whole sar clocks
	wire        track_start = state_q != swb_track && state_d == swb_track;
	wire        conv_end  = sar_tick && idx_q == 4'h0;
	wire [11:0] sample    = sar_step(code_q, idx_q, comp_in);
	wire [15:0] acc_sum   = acc_q + {4'h0, sample};
	wire        last      = nsamp_q == target;

	// justification applies to single samples only; a sum has no msb
	wire [15:0] just_res  = (left_just && target == 7'h01)
		? (res12 ? acc_q << `SWB_LSH12 : acc_q << `SWB_LSH10)
		: acc_q;
	wire        win_in    = just_res > window_lower_limit
		&& just_res < window_upper_limit;
	wire        win_out   = just_res < window_lower_limit
		|| just_res > window_upper_limit;
	wire        win_hit   = win_outside ? win_out : win_in;
	wire        win_set   = state_q == swb_done && win_hit;

	// sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			swb_idle: begin
				if (start && enable) begin
					state_d = burst_en ? swb_wake : swb_track;
				end
			end
			swb_wake: begin
				if (wake_q == 8'(`SWB_WAKE_CYC - 1)) begin
					state_d = swb_track;
				end
			end
			swb_track: begin
				if (track_end) begin
					state_d = swb_convert;
				end
			end
			swb_convert: begin
				if (conv_end) begin
					state_d = swb_gap;
				end
			end
			// rate spacing waits here, so low-power tracking stays three sar clocks
			swb_gap: begin
				state_d = last ? swb_done
					: gap_q == 11'h000 ? swb_track : swb_gap;
			end
			swb_done: begin
				state_d = swb_idle;
			end
			default: begin
				state_d = swb_idle;
			end
		endcase
	end

	// state and sar clock divider
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= swb_idle;
			div_q   <= 2'h0;
		end else begin
			state_q <= state_d;
			div_q   <= (sar_tick || track_start) ? 2'h0 : div_q + 2'h1;
		end
	end

	// wake and tracking counters
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_q <= 8'h00;
			trk_q  <= 2'h0;
		end else begin
			wake_q <= state_q == swb_wake ? wake_q + 8'h01 : 8'h00;
			if (state_q != swb_track) begin
				trk_q <= 2'h0;
			end else if (sar_tick) begin
				trk_q <= trk_q + 2'h1;
			end
		end
	end

	// successive approximation and sample rate spacing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			idx_q  <= 4'h0;
			code_q <= 12'h000;
			gap_q  <= 11'h000;
		end else if (state_q != swb_convert && state_d == swb_convert) begin
			idx_q  <= msb_idx;
			code_q <= 12'h001 << msb_idx;
			gap_q  <= period;
		end else begin
			if (gap_q != 11'h000) begin
				gap_q <= gap_q - 11'h001;
			end
			if (state_q == swb_convert && sar_tick) begin
				code_q <= sample;
				idx_q  <= conv_end ? 4'h0 : idx_q - 4'h1;
			end
		end
	end

	// accumulator restarts with each request
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_q   <= 16'h0000;
			nsamp_q <= 7'h00;
		end else if (state_q == swb_idle && state_d != swb_idle) begin
			acc_q   <= 16'h0000;
			nsamp_q <= 7'h00;
		end else if (state_q == swb_convert && conv_end) begin
			acc_q   <= acc_sum;
			nsamp_q <= nsamp_q + 7'h01;
		end
	end

	// result, pulse, sticky flag (set beats clear), analog power
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			result_q <= `SWB_RESULT_RST;
			valid_q  <= 1'b0;
			flag_q   <= 1'b0;
			power_q  <= 1'b0;
		end else begin
			valid_q <= state_q == swb_done;
			if (state_q == swb_done) begin
				result_q <= just_res;
			end
			flag_q  <= win_set || (flag_q && !flag_clear);
			power_q <= burst_en ? (state_d != swb_idle
				&& state_d != swb_done) : enable;
		end
	end

	assign analog_power            = power_q;
	assign track_en                = state_q == swb_track;
	assign sar_code                = code_q;
	assign busy                    = state_q != swb_idle;
	assign conversion_result       = result_q;
	assign result_valid            = valid_q;
	assign window_compare_irq_flag = flag_q;
	assign factory_temp_offset_high = TEMP_OFFSET[15:8];
	assign factory_temp_offset_low  = TEMP_OFFSET[7:0];

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_burst_end;
		state_q == swb_done && burst_en;
	endsequence
	property p_burst_off;
		s_burst_end |=> !analog_power ##1 !busy;
	endproperty
	a_burst_off: assert property (p_burst_off)
		else $error("burst did not shut the converter down");

	property p_acc;
		result_valid && !(left_just
			&& (accum_sel == 3'h0 || accum_sel > 3'h5))
			|-> conversion_result == acc_q;
	endproperty
	a_acc: assert property (p_acc)
		else $error("result differs from accumulator");

	property p_rate;
		state_q == swb_gap ##1 state_q == swb_track ##1 state_q == swb_convert
			|-> $past(gap_q, 1) == 11'h000;
	endproperty
	a_rate: assert property (p_rate)
		else $error("conversion started before rate period");

	property p_lp_track;
		state_q == swb_track && lp_track ##1 state_q == swb_convert
			|-> $past(trk_q, 1) == 2'h2 && $past(sar_tick, 1);
	endproperty
	a_lp_track: assert property (p_lp_track)
		else $error("low-power tracking not three sar clocks");

	property p_track_align;
		state_q != swb_track ##1 state_q == swb_track |-> div_q == 2'h0;
	endproperty
	a_track_align: assert property (p_track_align)
		else $error("tracking not aligned to a sar clock");

	property p_inside;
		result_valid && !win_outside
			&& conversion_result > window_lower_limit
			&& conversion_result < window_upper_limit
			|-> window_compare_irq_flag;
	endproperty
	a_inside: assert property (p_inside)
		else $error("inside hit did not set flag");

	property p_outside;
		result_valid && win_outside
			&& (conversion_result < window_lower_limit
			|| conversion_result > window_upper_limit)
			|-> window_compare_irq_flag;
	endproperty
	a_outside: assert property (p_outside)
		else $error("outside hit did not set flag");

	property p_ten_bit;
		result_valid && !res12 && accum_sel == 3'h0 && !left_just
			|-> conversion_result[15:10] == 6'h00;
	endproperty
	a_ten_bit: assert property (p_ten_bit)
		else $error("10-bit result out of range");

	property p_toff;
		##1 $stable({factory_temp_offset_high, factory_temp_offset_low});
	endproperty
	a_toff: assert property (p_toff)
		else $error("temperature offset changed");

	property p_flag_hold;
		window_compare_irq_flag && !flag_clear |=> window_compare_irq_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without clear");

	property p_left;
		result_valid && left_just && accum_sel == 3'h0 && !res12
			|-> conversion_result[5:0] == 6'h00;
	endproperty
	a_left: assert property (p_left)
		else $error("left-justified result misaligned");
endmodule

// ### shared/swb_defs.svh
// constants for the sar converter burst and window control block
// assumes a 100 MHz system clock; included by the top module and the bench
`ifndef SWB_DEFS_SVH
`define SWB_DEFS_SVH

`define SWB_CLK_NS        10
// sar clock is the system clock divided down
`define SWB_SAR_DIV       4
// low-power tracking length in sar clocks
`define SWB_TRACK_LP_SAR  3
// analog wake-up time before the first burst sample
`define SWB_WAKE_NS       1700
`define SWB_WAKE_CYC      ((`SWB_WAKE_NS + `SWB_CLK_NS - 1) / `SWB_CLK_NS)
// top sample rates per resolution
`define SWB_RATE10_KSPS   300
`define SWB_RATE12_KSPS   75
`define SWB_PER10_CYC     ((1000000 + `SWB_RATE10_KSPS * `SWB_CLK_NS - 1) \
	/ (`SWB_RATE10_KSPS * `SWB_CLK_NS))
`define SWB_PER12_CYC     ((1000000 + `SWB_RATE12_KSPS * `SWB_CLK_NS - 1) \
	/ (`SWB_RATE12_KSPS * `SWB_CLK_NS))
// msb index and left-justify shift per resolution
`define SWB_MSB10         4'h9
`define SWB_MSB12         4'hb
`define SWB_LSH10         6
`define SWB_LSH12         4
// reset values
`define SWB_RESULT_RST    16'h0000
`define SWB_TOFF_RST      16'h0200

`endif

// ### shared/swb_pkg.sv
// types for the sar converter burst and window control block
// no assumptions beyond a systemverilog compiler
package swb_pkg;
	typedef enum logic [2:0] {
		swb_idle,
		swb_wake,
		swb_track,
		swb_convert,
		swb_gap,
		swb_done
	} swb_state_e;

	// accumulate count select: 0..5 gives 1,4,8,16,32,64 samples
	typedef logic [2:0] swb_acc_t;
endpackage
